// file: irh_pkg.sv
// constants, register map and state codes of the infrared carrier transceiver host port
package irh_pkg;
    // ============================================================
    // register indices on the transceiver control bus
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_SYSF0  = 4'h1;
    localparam logic [3:0] ADDR_SYSF1  = 4'h2;
    localparam logic [3:0] ADDR_SYSF2  = 4'h3;
    localparam logic [3:0] ADDR_SYSF3  = 4'h4;
    localparam logic [3:0] ADDR_CARF0  = 4'h5;
    localparam logic [3:0] ADDR_CARF1  = 4'h6;
    localparam logic [3:0] ADDR_CARF2  = 4'h7;
    localparam logic [3:0] ADDR_WORDH  = 4'h9;
    localparam logic [3:0] ADDR_WORDL  = 4'hA;
    localparam logic [3:0] ADDR_STAT   = 4'hB;
    // ============================================================
    // control register fields
    localparam int CTRL_ENABLE   = 7;
    localparam int CTRL_DUTY33   = 6;
    localparam int CTRL_OUTPOL   = 5;
    localparam int CTRL_DISOE    = 4;
    localparam int CTRL_USRMAX   = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // status register fields
    localparam int STAT_BUSY     = 7;
    localparam int STAT_TIP      = 6;
    localparam int STAT_PEROFL   = 4;
    localparam int STAT_PULOFL   = 3;
    localparam int STAT_DATA_ERROR_FLAG   = 2;
    localparam int STAT_RX_FREQ_VALID_FLAG    = 1;
    localparam int STAT_BUFRDY   = 0;
    // ============================================================
    // widths and limits
    localparam int SYSF_W        = 28;
    localparam int CARF_W        = 24;
    localparam int PER_W         = 16;
    localparam int ON_SEL_BIT    = 15;
    localparam logic [14:0] CNT_MAX   = 15'h7FFF;
    localparam logic [15:0] PER_MAX   = 16'hFFFF;
    localparam logic [4:0]  DIV_STEPS = 5'h1C;
    // ============================================================
    // engine states, one-hot
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_TX   = 3'b010,
        ST_RX   = 3'b100
    } irh_state_e;
endpackage

// file: irh_host_port.sv
// infrared carrier transceiver: host register port, carrier transmitter and learning receiver
// Notes on behaviour
// - transmit: missing next word sets data error
// - data error sticks until control write/event
// - acquire_mode_select: ready marks word, low read clears
// - acquire_mode_select: unread word at next count errors
// - ready pin copies ready flag
// - fault pin copies data error flag
// - acquire_mode_select: frequency valid set, byte0 read clears
// - control write or event clears frequency valid
// - acquire_mode_select: counter at maximum sets overflow flag
// - period overflow: flag, drop edge, restart
// - system frequency 28 bits, top nibble ignored
// - carrier frequency 24 bits, read/write
// - acquire_mode_select: measure carrier once per ON group, at its second edge
// - carrier divider is system over carrier
// - bit 15 selects ON/OFF, 14:0 count
// - zero count is treated as one
// - learned count saturates, modes exclusive
// - transmit: word fetch sets buffer ready
// - busy pin copies busy flag
`timescale 1ns/1ps
`default_nettype none
module irh_host_port
    import irh_pkg::*;
(
    input  wire logic       SYS_CLK_I,        // system clock, 100 MHz
    input  wire logic       RESET_N_I,        // synchronous reset, active low
    input  wire logic [3:0] REG_ADDR_I,       // register index
    input  wire logic       REG_WR_I,         // write strobe, one cycle
    input  wire logic       REG_RD_I,         // read strobe, one cycle
    input  wire logic [7:0] REG_WDATA_I,      // write data
    output logic      [7:0] REG_RDATA_O,      // read data, the cycle after the strobe
    input  wire logic       EVENT_TRIGGER_I,  // event trigger pin, rising starts
    input  wire logic       ACQUIRE_MODE_I,   // 1 acquire_mode_select, 0 transmit
    input  wire logic       INFRARED_I,       // received carrier
    output logic            IR_OUT_O,         // modulated carrier out
    output logic            BUFFER_READY_O,   // buffer ready pin
    output logic            FAULT_O,          // data error pin
    output logic            BUSY_O            // busy pin
);
    import irh_pkg::*;

    // ============================================================
    // pin synchronisers: three stages, change taken when 2nd and 3rd agree
    logic [2:0] s1_q, s2_q, s3_q, filt_q, filt_prev_q;
    logic [2:0] filt_d;
    assign filt_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            s1_q        <= 3'h0;
            s2_q        <= 3'h0;
            s3_q        <= 3'h0;
            filt_q      <= 3'h0;
            filt_prev_q <= 3'h0;
        end
        else
        begin
            s1_q        <= {EVENT_TRIGGER_I, ACQUIRE_MODE_I, INFRARED_I};
            s2_q        <= s1_q;
            s3_q        <= s2_q;
            filt_q      <= filt_d;
            filt_prev_q <= filt_q;
        end
    end
    wire exe_rise = filt_q[2] & ~filt_prev_q[2];
    wire exe_lvl  = filt_q[2];
    wire acquire_mode_select    = filt_q[1];
    wire ir_rise  = filt_q[0] & ~filt_prev_q[0];

    // ============================================================
    // register decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
        hit = (a == idx);
    endfunction
    wire wr_ctrl  = REG_WR_I & hit(REG_ADDR_I, ADDR_CTRL);
    wire wr_carf0 = REG_WR_I & hit(REG_ADDR_I, ADDR_CARF0);
    wire wr_wordh = REG_WR_I & hit(REG_ADDR_I, ADDR_WORDH);
    wire wr_wordl = REG_WR_I & hit(REG_ADDR_I, ADDR_WORDL);
    wire rd_wordl = REG_RD_I & hit(REG_ADDR_I, ADDR_WORDL);
    wire rd_carf0 = REG_RD_I & hit(REG_ADDR_I, ADDR_CARF0);
    wire clr_all  = wr_ctrl | exe_rise;   // rewrite or new event clears flags

    logic [7:0]        ctrl_q;
    logic [SYSF_W-1:0] sysf_q;
    logic [CARF_W-1:0] carf_q;
    logic [15:0]       word_q;
    logic [7:0]        word_hi_q;
    irh_state_e        state_q;
    logic              buf_rdy_q, err_q, rx_freq_valid_flag_q, pulofl_q, perofl_q;

    // ============================================================
    // divider: shared by carrier setup (sys/carrier) and learning (sys/period)
    logic [SYSF_W-1:0] div_num_q, div_quo_q;
    logic [CARF_W-1:0] div_den_q;
    logic [CARF_W:0]   div_rem_q;
    logic [4:0]        div_cnt_q;
    logic              div_run_q, div_rx_q;
    logic [15:0]       n_div_q;
    logic [CARF_W:0]   rem_sh;
    logic              rem_ge;
    logic              rx_div_start;
    logic [PER_W-1:0]  period_q, per_cnt_q;
    assign rem_sh = {div_rem_q[CARF_W-1:0], div_num_q[SYSF_W-1]};
    assign rem_ge = (rem_sh >= {1'b0, div_den_q});
    wire div_done = div_run_q & (div_cnt_q == 5'h01);
    wire [SYSF_W-1:0] quo_next = {div_quo_q[SYSF_W-2:0], rem_ge};
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            div_num_q <= '0;
            div_quo_q <= '0;
            div_den_q <= '0;
            div_rem_q <= '0;
            div_cnt_q <= 5'h00;
            div_run_q <= 1'b0;
            div_rx_q  <= 1'b0;
            n_div_q   <= 16'h0001;
        end
        else if (wr_carf0 | rx_div_start)
        begin
            div_num_q <= sysf_q;
            div_den_q <= rx_div_start ? {8'h00, per_cnt_q + 16'h0001} : {carf_q[23:8], REG_WDATA_I};
            div_rem_q <= '0;
            div_quo_q <= '0;
            div_cnt_q <= DIV_STEPS;
            div_run_q <= 1'b1;
            div_rx_q  <= rx_div_start;
        end
        else if (div_run_q)
        begin
            div_rem_q <= rem_ge ? rem_sh - {1'b0, div_den_q} : rem_sh;
            div_num_q <= {div_num_q[SYSF_W-2:0], 1'b0};
            div_quo_q <= quo_next;
            div_cnt_q <= div_cnt_q - 5'h01;
            div_run_q <= ~div_done;
            // carrier step count saturates at 16 bits; never below one
            if (div_done && !div_rx_q)
                n_div_q <= (|quo_next[27:16]) ? PER_MAX :
                           ((quo_next[15:0] == 16'h0000) ? 16'h0001 : quo_next[15:0]);
        end
    end

    // ============================================================
    // control, frequency and data word registers
    wire       emit_now;
    wire [15:0] emit_word;
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            ctrl_q    <= CTRL_RESET;
            sysf_q    <= '0;
            carf_q    <= '0;
            word_q    <= 16'h0000;
            word_hi_q <= 8'h00;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= REG_WDATA_I;
            // top nibble of the highest byte is dropped
            if (REG_WR_I && hit(REG_ADDR_I, ADDR_SYSF3))
                sysf_q[27:24] <= REG_WDATA_I[3:0];
            if (REG_WR_I && hit(REG_ADDR_I, ADDR_SYSF2))
                sysf_q[23:16] <= REG_WDATA_I;
            if (REG_WR_I && hit(REG_ADDR_I, ADDR_SYSF1))
                sysf_q[15:8] <= REG_WDATA_I;
            if (REG_WR_I && hit(REG_ADDR_I, ADDR_SYSF0))
                sysf_q[7:0] <= REG_WDATA_I;
            if (REG_WR_I && hit(REG_ADDR_I, ADDR_CARF2))
                carf_q[23:16] <= REG_WDATA_I;
            if (REG_WR_I && hit(REG_ADDR_I, ADDR_CARF1))
                carf_q[15:8] <= REG_WDATA_I;
            if (wr_carf0)
                carf_q[7:0] <= REG_WDATA_I;
            if (div_done && div_rx_q)
                carf_q <= quo_next[CARF_W-1:0];
            // upper byte waits; the low byte commits the whole word
            if (wr_wordh)
                word_hi_q <= REG_WDATA_I;
            if (emit_now)
                word_q <= emit_word;
            else if (wr_wordl)
                word_q <= {word_hi_q, REG_WDATA_I};
        end
    end

    // ============================================================
    // engine state and counters
    logic [14:0]      cyc_left_q, on_cnt_q, off_cnt_q;
    logic [PER_W-1:0] off_tick_q;
    logic             cur_on_q, have_edge_q, in_on_q, meas_pend_q, ir_out_q;
    wire  [14:0]      cnt_max = ctrl_q[CTRL_USRMAX] ? word_q[14:0] : CNT_MAX;
    wire  start_ok    = exe_rise & ctrl_q[CTRL_ENABLE];
    wire  tx_step_end = (state_q == ST_TX) & (per_cnt_q >= n_div_q - 16'h0001);
    wire  tx_word_end = tx_step_end & (cyc_left_q == 15'h0001);
    // a fetch happens at start and at each word end while the trigger holds, if a word waits (ready low); else underrun
    wire  tx_fetch    = ((start_ok & ~acquire_mode_select) | (tx_word_end & exe_lvl)) & ~buf_rdy_q;
    wire  tx_underrun = ((start_ok & ~acquire_mode_select) | (tx_word_end & exe_lvl)) & buf_rdy_q;
    wire  rx_on       = state_q == ST_RX;
    wire  per_ovf     = rx_on & have_edge_q & in_on_q & (per_cnt_q == PER_MAX);
    wire  gap_seen    = rx_on & in_on_q & ({1'b0, per_cnt_q} > {period_q, 1'b0});
    wire  off_tick    = rx_on & ~in_on_q & (off_tick_q >= period_q);
    wire  on_begin    = rx_on & ir_rise & ~in_on_q;
    // a learned word is handed over at each ON/OFF boundary
    assign emit_now   = (gap_seen | (on_begin & (off_cnt_q != 15'h0000)));
    assign emit_word  = gap_seen ? {1'b1, on_cnt_q} : {1'b0, off_cnt_q};
    assign rx_div_start = rx_on & ir_rise & have_edge_q & meas_pend_q & ~div_run_q;
    wire  [14:0] tx_cnt = (word_q[14:0] == 15'h0000) ? 15'h0001 : word_q[14:0];
    wire  [15:0] duty_lim = ctrl_q[CTRL_DUTY33] ? n_div_q / 16'h0003 : n_div_q >> 1;

    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
            state_q <= ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (start_ok)
                        state_q <= acquire_mode_select ? ST_RX : (buf_rdy_q ? ST_IDLE : ST_TX);
                ST_TX:
                    if (tx_word_end && (!exe_lvl || buf_rdy_q))
                        state_q <= ST_IDLE;
                ST_RX:
                    if (!exe_lvl || !ctrl_q[CTRL_ENABLE])
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // transmitter: carrier steps of n_div cycles, count words from the buffer
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            cyc_left_q <= 15'h0001;
            cur_on_q   <= 1'b0;
        end
        else if (tx_fetch)
        begin
            cyc_left_q <= tx_cnt;
            cur_on_q   <= word_q[ON_SEL_BIT];
        end
        else if (tx_step_end && cyc_left_q != 15'h0001)
            cyc_left_q <= cyc_left_q - 15'h0001;
    end

    // shared step counter: carrier step in transmit, edge spacing in learning
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I || state_q == ST_IDLE || tx_step_end || per_ovf || (rx_on && ir_rise))
            per_cnt_q <= 16'h0000;
        else if (per_cnt_q != PER_MAX)
            per_cnt_q <= per_cnt_q + 16'h0001;
    end

    // learning receiver: period capture, ON/OFF grouping with saturating counts
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I || !rx_on)
        begin
            have_edge_q <= 1'b0;
            in_on_q     <= 1'b0;
            meas_pend_q <= 1'b1;
            period_q    <= PER_MAX;
            on_cnt_q    <= 15'h0000;
            off_cnt_q   <= 15'h0000;
            off_tick_q  <= 16'h0000;
        end
        else
        begin
            if (per_ovf)
                have_edge_q <= 1'b0;
            else if (ir_rise)
            begin
                have_edge_q <= 1'b1;
                if (have_edge_q)
                    period_q <= per_cnt_q + 16'h0001;
            end
            // frequency taken once per ON group, on its second edge
            if (on_begin)
                meas_pend_q <= 1'b1;
            else if (rx_div_start)
                meas_pend_q <= 1'b0;
            if (on_begin)
            begin
                in_on_q   <= 1'b1;
                on_cnt_q  <= 15'h0001;
                off_cnt_q <= 15'h0000;
            end
            else if (gap_seen)
            begin
                in_on_q    <= 1'b0;
                off_cnt_q  <= 15'h0001;
                off_tick_q <= 16'h0000;
            end
            else if (in_on_q && ir_rise && on_cnt_q < cnt_max)
                on_cnt_q <= on_cnt_q + 15'h0001;
            else if (off_tick)
            begin
                off_tick_q <= 16'h0000;
                if (off_cnt_q < cnt_max)
                    off_cnt_q <= off_cnt_q + 15'h0001;
            end
            else if (!in_on_q)
                off_tick_q <= off_tick_q + 16'h0001;
        end
    end
    wire cnt_sat = rx_on & ((in_on_q & ir_rise & on_cnt_q >= cnt_max) |
                            (off_tick & off_cnt_q >= cnt_max));

    // ============================================================
    // status flags: a set in the clearing cycle wins
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            buf_rdy_q <= 1'b1;
            err_q     <= 1'b0;
            rx_freq_valid_flag_q   <= 1'b0;
            pulofl_q  <= 1'b0;
            perofl_q  <= 1'b0;
        end
        else
        begin
            if (tx_fetch || emit_now)
                buf_rdy_q <= 1'b1;
            else if (wr_wordl || (rd_wordl && rx_on))
                buf_rdy_q <= 1'b0;
            if (tx_underrun || (emit_now && buf_rdy_q))
                err_q <= 1'b1;
            else if (clr_all)
                err_q <= 1'b0;
            if (div_done && div_rx_q)
                rx_freq_valid_flag_q <= 1'b1;
            else if (rd_carf0 || clr_all)
                rx_freq_valid_flag_q <= 1'b0;
            if (cnt_sat)
                pulofl_q <= 1'b1;
            else if (clr_all)
                pulofl_q <= 1'b0;
            if (per_ovf)
                perofl_q <= 1'b1;
            else if (clr_all)
                perofl_q <= 1'b0;
        end
    end

    // carrier output: mark part of each step while ON; optionally muted on error
    wire ir_mark = (state_q == ST_TX) & cur_on_q & (per_cnt_q < duty_lim) &
                   ~(err_q & ctrl_q[CTRL_DISOE]);
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
            ir_out_q <= 1'b0;
        else
            ir_out_q <= ir_mark ^ ctrl_q[CTRL_OUTPOL];
    end

    // ============================================================
    // read mux, registered; unmapped indices read zero
    wire busy = (state_q != ST_IDLE) | div_run_q;
    wire [7:0] status = {busy, state_q != ST_IDLE, 1'b0, perofl_q, pulofl_q,
                         err_q, rx_freq_valid_flag_q, buf_rdy_q};
    logic [7:0] rdata_d, rdata_q;
    always_comb
    begin
        case (REG_ADDR_I)
            ADDR_CTRL:  rdata_d = ctrl_q;
            ADDR_CARF0: rdata_d = carf_q[7:0];
            ADDR_CARF1: rdata_d = carf_q[15:8];
            ADDR_CARF2: rdata_d = carf_q[23:16];
            ADDR_WORDH: rdata_d = word_q[15:8];
            ADDR_WORDL: rdata_d = word_q[7:0];
            ADDR_STAT:  rdata_d = status;
            default:    rdata_d = 8'h00;
        endcase
    end
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
            rdata_q <= 8'h00;
        else if (REG_RD_I)
            rdata_q <= rdata_d;
    end

    assign REG_RDATA_O    = rdata_q;
    assign IR_OUT_O       = ir_out_q;
    assign BUFFER_READY_O = buf_rdy_q;
    assign FAULT_O        = err_q;
    assign BUSY_O         = busy;

    // ============================================================
    // checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_hi_write;
        wr_wordh && !wr_wordl && !emit_now;
    endsequence
    sequence s_zero_fetch;
        tx_fetch && word_q[14:0] == 15'h0000;
    endsequence
    chk_ready_pin_copy: assert property (BUFFER_READY_O == status[STAT_BUFRDY])
        else $error("ready pin differs from flag");
    chk_fault_pin_copy: assert property (FAULT_O == status[STAT_DATA_ERROR_FLAG])
        else $error("fault pin differs from flag");
    chk_busy_pin_copy: assert property (BUSY_O == status[STAT_BUSY])
        else $error("busy pin differs from flag");
    chk_err_stays_set: assert property (err_q && !clr_all |=> err_q)
        else $error("data error dropped without clear");
    chk_tx_underrun_err: assert property (tx_word_end && exe_lvl && buf_rdy_q |=> err_q)
        else $error("underrun did not raise error");
    chk_rx_overrun_err: assert property (emit_now && buf_rdy_q |=> err_q && buf_rdy_q)
        else $error("overrun did not raise error");
    chk_rx_read_clears: assert property (rx_on && rd_wordl && !emit_now |=> !buf_rdy_q)
        else $error("low byte read left ready set");
    chk_freq_read_clear: assert property ((rd_carf0 || clr_all) && !div_done |=> !rx_freq_valid_flag_q)
        else $error("frequency valid not cleared");
    chk_zero_as_one: assert property (s_zero_fetch |=> cyc_left_q == 15'h0001)
        else $error("zero count not taken as one");
    chk_hi_byte_held: assert property (s_hi_write |=> $stable(word_q))
        else $error("upper byte reached word early");
    chk_period_restart: assert property (per_ovf |=> perofl_q && !have_edge_q)
        else $error("period overflow not handled");
endmodule
`default_nettype wire

// file: irh_ir_src.sv
// infrared carrier source standing in for the remote transmitter
`timescale 1ns/1ps
`default_nettype none
module irh_ir_src #(
    parameter int HALF = 10  // half period of the carrier in clock cycles
)
(
    input  wire logic clk_i,  // system clock
    input  wire logic en_i,   // burst enable
    output logic      ir_o    // carrier seen by the receiver
);
    int cnt_q;
    // ============================================================
    // carrier burst
    // dark between bursts, so the receiver never sees a stale edge
    always_ff @(posedge clk_i)
    begin
        if (!en_i)
        begin
            cnt_q <= 0;
            ir_o  <= 1'b0;
        end
        else if (cnt_q == HALF - 1)
        begin
            cnt_q <= 0;
            ir_o  <= ~ir_o;
        end
        else
            cnt_q <= cnt_q + 1;
    end
endmodule
`default_nettype wire

// file: tb.sv
// testbench of the infrared transceiver host port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import irh_pkg::*;
    logic       clk, rst_n, wr, rd, trig, acquire_mode_select, ir, ir_out, rdy, fault, busy, src_en;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    int         fails, compares, cyc;

    irh_host_port DUT (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .EVENT_TRIGGER_I(trig),
        .ACQUIRE_MODE_I(acquire_mode_select), .INFRARED_I(ir), .IR_OUT_O(ir_out), .BUFFER_READY_O(rdy),
        .FAULT_O(fault), .BUSY_O(busy));
    irh_ir_src #(.HALF(10)) src (.clk_i(clk), .en_i(src_en), .ir_o(ir));

    // ============================================================
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // the whole run needs about four hundred cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            summarize();
        end
    end

    // ============================================================
    // access and check tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            fails++;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // data is registered at the strobe edge and holds, so one spare edge is safe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1 d = rdata;
    endtask
    // bounded wait for ready (sel 0) or fault (sel 1)
    task automatic wait_hi(input int sel, input int lim);
        for (int n = 0; n < lim; n++)
        begin
            @(posedge clk);
            #1;
            if ((sel == 0 ? rdy : fault) === 1'b1)
                break;
        end
    endtask
    task automatic summarize;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ============================================================
    // main sequence
    initial
    begin
        logic [7:0] d;
        {rst_n, wr, rd, trig, acquire_mode_select, src_en, addr, wdata, fails, compares, cyc} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({5'h00, busy, fault, rdy}, 8'h01);
        rd_reg(ADDR_STAT, d);
        chk(d, 8'h01);
        // system frequency 200 with junk in the ignored nibble, carrier 20
        wr_reg(ADDR_SYSF3, 8'hF0);
        wr_reg(ADDR_SYSF2, 8'h00);
        wr_reg(ADDR_SYSF1, 8'h00);
        wr_reg(ADDR_SYSF0, 8'hC8);
        rd_reg(ADDR_SYSF0, d);
        chk(d, 8'h00);
        wr_reg(ADDR_CARF2, 8'h00);
        wr_reg(ADDR_CARF1, 8'h00);
        wr_reg(ADDR_CARF0, 8'h14);
        @(posedge clk);
        #1;
        chk({7'h00, busy}, 8'h01);
        repeat (30) @(posedge clk);
        rd_reg(ADDR_CARF0, d);
        chk(d, 8'h14);
        chk({7'h00, busy}, 8'h00);
        // transmit one ON word of three steps, then starve the buffer
        wr_reg(ADDR_CTRL, 8'h80);
        wr_reg(ADDR_WORDH, 8'h80);
        wr_reg(ADDR_WORDL, 8'h03);
        @(posedge clk);
        #1;
        chk({7'h00, rdy}, 8'h00);
        trig <= 1'b1;
        wait_hi(0, 20);
        chk({6'h00, busy, rdy}, 8'h03);
        // step of ten cycles, mark for the first five
        @(posedge clk);
        #1;
        chk({7'h00, ir_out}, 8'h01);
        repeat (5) @(posedge clk);
        #1;
        chk({7'h00, ir_out}, 8'h00);
        wait_hi(1, 200);
        chk({7'h00, fault}, 8'h01);
        rd_reg(ADDR_STAT, d);
        chk(d & 8'h04, 8'h04);
        trig <= 1'b0;
        wr_reg(ADDR_CTRL, 8'h80);
        @(posedge clk);
        #1;
        chk({7'h00, fault}, 8'h00);
        // OFF word of count zero runs one step, then underruns
        wr_reg(ADDR_WORDH, 8'h00);
        wr_reg(ADDR_WORDL, 8'h00);
        trig <= 1'b1;
        wait_hi(0, 20);
        wait_hi(1, 15);
        chk({7'h00, fault}, 8'h01);
        trig <= 1'b0;
        // acquire_mode_select one burst of ten carrier periods; the new event clears the error
        wr_reg(ADDR_WORDH, 8'h00);
        wr_reg(ADDR_WORDL, 8'h00);
        acquire_mode_select <= 1'b1;
        trig  <= 1'b1;
        repeat (8) @(posedge clk);
        src_en <= 1'b1;
        repeat (200) @(posedge clk);
        src_en <= 1'b0;
        wait_hi(0, 300);
        chk({7'h00, rdy}, 8'h01);
        rd_reg(ADDR_WORDH, d);
        chk(d & 8'h80, 8'h80);
        rd_reg(ADDR_WORDL, d);
        chk({7'h00, rdy}, 8'h00);
        rd_reg(ADDR_STAT, d);
        chk(d & 8'h06, 8'h02);
        rd_reg(ADDR_CARF0, d);
        chk(d, 8'h0A);
        rd_reg(ADDR_STAT, d);
        chk(d & 8'h02, 8'h00);
        trig <= 1'b0;
        summarize();
    end
endmodule
`default_nettype wire
